// [rtl/ufd_fifo_dma.sv]
`timescale 1ns/1ns
// What this block does
// - Two sixteen-byte queues, transmit and receive
// - Receive threshold selectable: 1, 4, 8, 14
// - Receive queue fills to sixteen past threshold
// - Transmitter loads byte as soon as present
// - Writes refused while transmit queue full
// - Transmit-empty interrupt while queue empty
// - First write into empty queue drops it
// - Re-emptying waits one character time
// - Two bytes held together cancel delay
// - Receive interrupt when count reaches threshold
// - Full receive queue rejects, sets overrun
// - Timeout after four idle character times
// - Read or new character clears timeout
// - Single mode: receive request while nonempty
// - Single mode: transmit request while empty
// - Multi mode: receive request threshold/timeout
// - Multi mode: transmit request while not full
// - Data ready sets on push, clears empty
// - Line status outranks received data
// - Write or identity read clears transmit-empty
// - Enables off: no threshold or timeout shown
module ufd_fifo_dma (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire ufd_pkg::ufd_bus_req_t bus_req,
  output logic [7:0]                 rd_data,
  input  wire ufd_pkg::ufd_char_t    rx_char,
  input  wire logic                  tx_shift_idle,
  input  wire logic                  rclk16,
  output logic                       tx_load,
  output logic [7:0]                 tx_byte,
  output logic                       intr,
  output logic                       rx_dma_req,
  output logic                       tx_dma_req
);
  import ufd_pkg::*;

  typedef struct packed {
    logic [15:0][7:0] txm;
    logic [15:0][7:0] rxm;
    logic [3:0]       txw;
    logic [3:0]       txr;
    logic [3:0]       rxw;
    logic [3:0]       rxr;
    logic [4:0]       txc;
    logic [4:0]       rxc;
    logic [2:0]       ier;
    logic             fen;
    logic [1:0]       trig;
    logic             dmam;
    logic [3:0]       lcr;
    logic             ovr;
    logic             dr;
    logic             thre;
    logic             two_seen;
    logic             tdly_on;
    logic [9:0]       tdly_cnt;
    logic [11:0]      to_cnt;
    logic             to;
    logic             rxdma;
    logic             txdma;
    logic             intr;
    logic             tx_load;
    logic [7:0]       tx_data;
    logic [7:0]       rdata;
    logic [3:0]       interrupt_identity_register;
    logic [2:0]       rsync;
    logic             rlev;
  } ufd_state_t;

  ufd_state_t s_q;
  ufd_state_t s_d;
  logic       tick;
  logic       tx_push;
  logic       tx_pop;
  logic       rx_push;
  logic       rx_pop;
  logic       wr_data;
  logic       tx_empty_ev;
  logic       tx_clr;
  logic       rx_clr;
  logic [4:0] txc_n;
  logic [4:0] rxc_n;

  // Threshold level for the two-bit selector
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      2'h3: trig_level = 5'h0E;
    endcase
  endfunction

  // Character length in 16x ticks: start, data, parity, stop bits
  function automatic logic [9:0] char_ticks(input logic [3:0] lcr);
    logic [9:0] bits;
    bits = 10'h007 + {8'h00, lcr[1:0]} + {9'h000, lcr[3]}
         + {9'h000, lcr[2]};
    char_ticks = 10'((bits * TICKS_PER_BIT) & 10'h3FF);
  endfunction

  // Next state: bus, queues, interrupt pacing and DMA requests
  always_comb
  begin
    s_d = s_q;
    // Rising edge of the 16x clock once the second and third agree
    tick = s_q.rsync[2] & s_q.rsync[1] & ~s_q.rlev;
    s_d.rsync = {s_q.rsync[1:0], rclk16};
    if (s_q.rsync[2] == s_q.rsync[1])
      s_d.rlev = s_q.rsync[2];

    wr_data = bus_req.wr && bus_req.addr == OFF_DATA;
    tx_push = wr_data && s_q.txc != CNT_FULL;
    tx_pop  = tx_shift_idle && s_q.txc != 5'h00 && !s_q.tx_load;
    rx_push = rx_char.valid && s_q.rxc != CNT_FULL;
    rx_pop  = bus_req.rd && bus_req.addr == OFF_DATA
              && s_q.rxc != 5'h00;
    // A queue clear overrides this cycle's moves, so flags follow it
    tx_clr = bus_req.wr && bus_req.addr == OFF_IIR
             && bus_req.wdata[FCR_TXCLR];
    rx_clr = bus_req.wr && bus_req.addr == OFF_IIR
             && bus_req.wdata[FCR_RXCLR];
    txc_n = tx_clr ? 5'h00
            : 5'(s_q.txc + {4'h0, tx_push} - {4'h0, tx_pop});
    rxc_n = rx_clr ? 5'h00
            : 5'(s_q.rxc + {4'h0, rx_push} - {4'h0, rx_pop});
    tx_empty_ev = tx_pop && !tx_clr && txc_n == 5'h00;

    // Queue storage and pointers, sixteen entries each
    if (tx_push)
    begin
      s_d.txm[s_q.txw] = bus_req.wdata;
      s_d.txw = 4'(s_q.txw + 4'h1);
    end
    if (tx_pop)
      s_d.txr = 4'(s_q.txr + 4'h1);
    if (rx_push)
    begin
      s_d.rxm[s_q.rxw] = rx_char.data;
      s_d.rxw = 4'(s_q.rxw + 4'h1);
    end
    if (rx_pop)
      s_d.rxr = 4'(s_q.rxr + 4'h1);
    s_d.txc = txc_n;
    s_d.rxc = rxc_n;
    s_d.tx_load = tx_pop;
    s_d.tx_data = s_q.txm[s_q.txr];

    // Full receive queue: extra character flags overrun
    if (rx_char.valid && s_q.rxc == CNT_FULL)
      s_d.ovr = 1'b1;
    else if (bus_req.rd && bus_req.addr == OFF_LSR)
      s_d.ovr = 1'b0;
    s_d.dr = rxc_n != 5'h00;

    // Control writes
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        OFF_IER: s_d.ier = bus_req.wdata[2:0];
        OFF_LCR: s_d.lcr = bus_req.wdata[3:0];
        OFF_IIR:
        begin
          s_d.fen  = bus_req.wdata[FCR_EN];
          s_d.dmam = bus_req.wdata[FCR_DMA];
          s_d.trig = bus_req.wdata[FCR_TRIG +: 2];
        end
        default: ;
      endcase
    end

    // Transmit-empty pacing; clears first, sets after so sets win
    s_d.two_seen = s_q.two_seen | (txc_n >= 5'h02);
    if (tx_push)
    begin
      s_d.thre = 1'b0;
      s_d.tdly_on = 1'b0;
    end
    if (bus_req.rd && bus_req.addr == OFF_IIR && s_q.interrupt_identity_register == ID_THRE)
      s_d.thre = 1'b0;
    if (s_q.tdly_on && tick && !tx_push)
    begin
      s_d.tdly_cnt = 10'(s_q.tdly_cnt - 10'h001);
      if (s_q.tdly_cnt == 10'h001)
      begin
        s_d.thre = 1'b1;
        s_d.tdly_on = 1'b0;
      end
    end
    if (tx_empty_ev)
    begin
      s_d.two_seen = 1'b0;
      if (s_q.two_seen)
        s_d.thre = 1'b1;
      else
      begin
        s_d.tdly_on = 1'b1;
        s_d.tdly_cnt = char_ticks(s_q.lcr);
      end
    end
    if (bus_req.wr && bus_req.addr == OFF_IIR
        && bus_req.wdata[FCR_EN] != s_q.fen && txc_n == 5'h00)
    begin
      s_d.thre = 1'b1;
      s_d.tdly_on = 1'b0;
    end

    // Receive timeout timer, counted in 16x ticks
    if (rx_push || rx_pop || rx_clr)
    begin
      s_d.to_cnt = 12'h000;
      s_d.to = 1'b0;
    end
    else if (s_q.rxc != 5'h00 && tick && !s_q.to)
    begin
      s_d.to_cnt = 12'(s_q.to_cnt + 12'h001);
      if (s_d.to_cnt == {char_ticks(s_q.lcr), 2'b00})
        s_d.to = 1'b1;
    end

    // DMA requests per mode
    if (!s_q.dmam)
    begin
      s_d.rxdma = rxc_n != 5'h00;
      s_d.txdma = txc_n == 5'h00;
    end
    else
    begin
      if (rxc_n == 5'h00)
        s_d.rxdma = 1'b0;
      else if (rxc_n >= trig_level(s_q.trig) || s_d.to)
        s_d.rxdma = 1'b1;
      s_d.txdma = txc_n != CNT_FULL;
    end

    // Interrupt identity by priority; enables off show nothing
    if (s_q.ier[2] && s_q.ovr)
      s_d.interrupt_identity_register = ID_LS;
    else if (s_q.ier[0] && s_q.rxc >= trig_level(s_q.trig))
      s_d.interrupt_identity_register = ID_RDA;
    else if (s_q.ier[0] && s_q.to)
      s_d.interrupt_identity_register = ID_TO;
    else if (s_q.ier[1] && s_q.thre)
      s_d.interrupt_identity_register = ID_THRE;
    else
      s_d.interrupt_identity_register = ID_NONE;
    s_d.intr = s_d.interrupt_identity_register != ID_NONE;

    // Read data, valid only the cycle after the read strobe
    s_d.rdata = 8'h00;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        OFF_DATA: s_d.rdata = s_q.rxm[s_q.rxr];
        OFF_IER:  s_d.rdata = {5'h00, s_q.ier};
        OFF_IIR:  s_d.rdata = {{2{s_q.fen}}, 2'b00, s_q.interrupt_identity_register};
        OFF_LCR:  s_d.rdata = {4'h0, s_q.lcr};
        OFF_LSR:  s_d.rdata = {1'b0,
                    s_q.txc == 5'h00 && tx_shift_idle && !s_q.tx_load,
                    s_q.txc == 5'h00, 3'b000, s_q.ovr, s_q.dr};
        default:  s_d.rdata = 8'h00;
      endcase
    end
    if (bus_req.wr && bus_req.addr == OFF_IIR)
    begin
      if (bus_req.wdata[FCR_RXCLR])
      begin
        s_d.rxw = 4'h0;
        s_d.rxr = 4'h0;
        s_d.rxc = 5'h00;
      end
      if (bus_req.wdata[FCR_TXCLR])
      begin
        s_d.txw = 4'h0;
        s_d.txr = 4'h0;
        s_d.txc = 5'h00;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_q          <= '0;
      s_q.ier      <= IER_RST;
      s_q.lcr      <= LCR_RST;
      s_q.thre     <= 1'b1;
      s_q.txdma    <= 1'b1;
      s_q.interrupt_identity_register      <= ID_NONE;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from the state register
  assign rd_data    = s_q.rdata;
  assign tx_load    = s_q.tx_load;
  assign tx_byte    = s_q.tx_data;
  assign intr       = s_q.intr;
  assign rx_dma_req = s_q.rxdma;
  assign tx_dma_req = s_q.txdma;

  // Checks
  a_tx_full_refuse: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_data && s_q.txc == CNT_FULL && !tx_pop)
    |=> s_q.txc == CNT_FULL)
    else $error("write taken into full transmit queue");
  a_rx_fill_full: assert property (@(posedge clk_sys) disable iff (srst)
    (s_q.rxc == 5'h0F && rx_char.valid && !rx_pop && !bus_req.wr)
    |=> s_q.rxc == CNT_FULL)
    else $error("receive queue stopped short of sixteen");
  a_overrun_set: assert property (@(posedge clk_sys) disable iff (srst)
    (rx_char.valid && s_q.rxc == CNT_FULL) |=> s_q.ovr)
    else $error("overrun not flagged");
  a_tx_autoload: assert property (@(posedge clk_sys) disable iff (srst)
    (s_q.txc != 5'h00 && tx_shift_idle && !s_q.tx_load)
    |=> tx_load && tx_byte == $past(s_q.txm[s_q.txr]))
    else $error("byte not handed to transmitter");
  a_thre_drop: assert property (@(posedge clk_sys) disable iff (srst)
    (tx_push && s_q.txc == 5'h00) |=> !s_q.thre ##1 s_q.interrupt_identity_register != ID_THRE)
    else $error("transmit-empty not dropped on write");
  a_two_no_delay: assert property (@(posedge clk_sys) disable iff (srst)
    (tx_empty_ev && s_q.two_seen) |=> s_q.thre)
    else $error("delay applied after two bytes held");
  a_rx_dma_single: assert property (@(posedge clk_sys) disable iff (srst)
    (!s_q.dmam && !$past(s_q.dmam)) |-> rx_dma_req == (s_q.rxc != 5'h00))
    else $error("single mode receive request wrong");
  a_tx_dma_multi: assert property (@(posedge clk_sys) disable iff (srst)
    (s_q.dmam && $past(s_q.dmam)) |-> tx_dma_req == (s_q.txc != CNT_FULL))
    else $error("multi mode transmit request wrong");
  a_to_clear: assert property (@(posedge clk_sys) disable iff (srst)
    (rx_push || rx_pop) |=> !s_q.to && s_q.to_cnt == 12'h000)
    else $error("timeout not cleared");
  a_ls_priority: assert property (@(posedge clk_sys) disable iff (srst)
    (s_q.ier[2] && s_q.ovr) |=> s_q.interrupt_identity_register == ID_LS && intr)
    else $error("line status not on top");
  a_polled_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    (s_q.ier == 3'h0) |=> s_q.interrupt_identity_register == ID_NONE)
    else $error("indication with all enables off");

endmodule

// [rtl/ufd_pkg.sv]
package ufd_pkg;

  // Queue geometry
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W      = 4;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  CNT_FULL   = 5'h10;

  // Register offsets
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER  = 3'h1;
  localparam logic [2:0] OFF_IIR  = 3'h2;
  localparam logic [2:0] OFF_LCR  = 3'h3;
  localparam logic [2:0] OFF_LSR  = 3'h5;

  // Field positions of the FIFO control write
  localparam int unsigned FCR_EN    = 0;
  localparam int unsigned FCR_RXCLR = 1;
  localparam int unsigned FCR_TXCLR = 2;
  localparam int unsigned FCR_DMA   = 3;
  localparam int unsigned FCR_TRIG  = 6;

  // Interrupt identity codes
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_THRE = 4'h2;
  localparam logic [3:0] ID_RDA  = 4'h4;
  localparam logic [3:0] ID_LS   = 4'h6;
  localparam logic [3:0] ID_TO   = 4'hC;

  // Reset values
  localparam logic [2:0] IER_RST = 3'h0;
  localparam logic [3:0] LCR_RST = 4'h3;

  // Timing: ticks of the 16x receiver clock per bit; TO_CHARS is unused, the timeout is four char times
  localparam logic [9:0] TICKS_PER_BIT = 10'h010;
  localparam logic [1:0] TO_CHARS      = 2'h3;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ufd_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ufd_char_t;

endpackage

// [sim/uart_fifo_dma_request_logic_tb.sv]
`timescale 1ns/1ns
module uart_fifo_dma_request_logic_tb;
  import ufd_pkg::*;
  logic         clk_sys;
  logic         srst;
  ufd_bus_req_t bus_req;
  ufd_char_t    rx_char;
  logic         rclk16;
  logic         stall;
  logic [7:0]   rd_data;
  logic [7:0]   tx_byte;
  logic         tx_shift_idle;
  logic         tx_load;
  logic         intr;
  logic         rx_dma_req;
  logic         tx_dma_req;
  int           num_errors;
  int           tests_run;
  logic [7:0]   d;

  ufd_fifo_dma dut (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
    .rd_data(rd_data), .rx_char(rx_char), .tx_shift_idle(tx_shift_idle),
    .rclk16(rclk16), .tx_load(tx_load), .tx_byte(tx_byte), .intr(intr),
    .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req));
  ufd_shift_model pm (.clk_sys(clk_sys), .srst(srst), .stall(stall),
    .tx_load(tx_load), .tx_byte(tx_byte), .tx_shift_idle(tx_shift_idle));

  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Receiver 16x clock, toggling every third system clock
  initial
  begin
    rclk16 = 1'b0;
    forever
    begin
      repeat (3) @(posedge clk_sys);
      rclk16 <= ~rclk16;
    end
  end

  // Verdict and end of run
  task complete_run;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus write and read, one strobe cycle each
  task bw(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus_req.addr  <= a;
    bus_req.wdata <= v;
    bus_req.wr    <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask
  task br(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    v = rd_data;
  endtask
  task push(input logic [7:0] v);
    @(posedge clk_sys);
    rx_char <= '{valid: 1'b1, data: v};
    @(posedge clk_sys);
    rx_char.valid <= 1'b0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wait_intr(input int lim);
    int i;
    for (i = 0; i < lim && intr !== 1'b1; i++)
      cyc(1);
    if (intr !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED intr wait expected 1 seen %b", intr);
      complete_run();
    end
  endtask

  // Outputs and status straight after reset
  task t_reset;
    cyc(1);
    chk("tx_dma_req", 8'h01, {7'h0, tx_dma_req});
    chk("rx_dma_req", 8'h00, {7'h0, rx_dma_req});
    chk("intr", 8'h00, {7'h0, intr});
    br(OFF_LSR, d);
    chk("lsr", 8'h60, d);
  endtask
  // Transmit queue filled past full with the shifter stalled
  task t_tx_full;
    int i;
    bw(OFF_IIR, 8'h09);
    stall <= 1'b1;
    for (i = 1; i <= 17; i++)
      bw(OFF_DATA, i[7:0]);
    cyc(2);
    chk("tx_dma_req", 8'h00, {7'h0, tx_dma_req});
    @(posedge clk_sys);
    stall <= 1'b0;
    for (i = 0; i < 1000 && pm.n_q < 6'h10; i++)
      cyc(1);
    if (pm.n_q < 6'h10)
    begin
      num_errors++;
      $display("CHECK FAILED tx drain expected 10 seen %h", pm.n_q);
      complete_run();
    end
    cyc(100);
    chk("tx count", 8'h10, {2'h0, pm.n_q});
    for (i = 0; i < 16; i++)
      chk("tx byte", i[7:0] + 8'h01, pm.got[i]);
    chk("tx_dma_req", 8'h01, {7'h0, tx_dma_req});
  endtask
  // Every trigger level, then fill to overrun and drain
  task t_rx;
    int         k;
    int         i;
    logic [7:0] lv [4];
    lv = '{8'h01, 8'h04, 8'h08, 8'h0E};
    bw(OFF_IER, 8'h05);
    for (k = 0; k < 4; k++)
    begin
      bw(OFF_IIR, {k[1:0], 6'h03});
      for (i = 1; i < lv[k]; i++)
        push(i[7:0]);
      cyc(3);
      chk("intr low", 8'h00, {7'h0, intr});
      push(lv[k]);
      cyc(3);
      chk("intr high", 8'h01, {7'h0, intr});
      chk("rx_dma_req", 8'h01, {7'h0, rx_dma_req});
    end
    br(OFF_IIR, d);
    chk("iir id", {4'h0, ID_RDA}, {4'h0, d[3:0]});
    for (i = 15; i <= 17; i++)
      push(i[7:0]);
    br(OFF_IIR, d);
    chk("iir id", {4'h0, ID_LS}, {4'h0, d[3:0]});
    br(OFF_LSR, d);
    chk("lsr rx", 8'h03, {6'h0, d[1:0]});
    for (i = 1; i <= 16; i++)
    begin
      br(OFF_DATA, d);
      chk("rx byte", i[7:0], d);
    end
    cyc(3);
    chk("rx_dma_req", 8'h00, {7'h0, rx_dma_req});
  endtask
  // Idle queue below threshold, timer restarted by a new character
  task t_timeout;
    bw(OFF_IIR, 8'hCB);
    push(8'h5A);
    cyc(2000);
    chk("rx_dma_req", 8'h00, {7'h0, rx_dma_req});
    push(8'h5B);
    cyc(2500);
    chk("intr", 8'h00, {7'h0, intr});
    wait_intr(1500);
    br(OFF_IIR, d);
    chk("iir id", {4'h0, ID_TO}, {4'h0, d[3:0]});
    chk("rx_dma_req", 8'h01, {7'h0, rx_dma_req});
  endtask
  // Transmit-empty interrupt, its delay and its cancellation
  task t_tx_delay;
    bw(OFF_IIR, 8'h05);
    bw(OFF_IER, 8'h02);
    cyc(3);
    chk("intr", 8'h01, {7'h0, intr});
    bw(OFF_DATA, 8'h77);
    cyc(3);
    chk("intr", 8'h00, {7'h0, intr});
    cyc(400);
    chk("intr", 8'h00, {7'h0, intr});
    wait_intr(1500);
    br(OFF_IIR, d);
    chk("iir id", {4'h0, ID_THRE}, {4'h0, d[3:0]});
    cyc(3);
    chk("intr", 8'h00, {7'h0, intr});
    @(posedge clk_sys);
    stall <= 1'b1;
    bw(OFF_DATA, 8'h21);
    bw(OFF_DATA, 8'h22);
    stall <= 1'b0;
    wait_intr(100);
  endtask

  // Main sequence
  initial
  begin
    srst       = 1'b1;
    bus_req    = '0;
    rx_char    = '0;
    stall      = 1'b0;
    num_errors = 0;
    tests_run  = 0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_tx_full();
    t_rx();
    t_timeout();
    t_tx_delay();
    complete_run();
  end
endmodule

// [sim/ufd_shift_model.sv]
`timescale 1ns/1ns
// Transmit shifter stand-in: logs each byte, then shifts for 20 cycles
module ufd_shift_model (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       stall,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_byte,
  output logic            tx_shift_idle
);
  logic [7:0] got [0:31];
  logic [5:0] n_q;
  logic [4:0] busy_q;
  // Ready only when not shifting and not held off by the bench
  assign tx_shift_idle = (busy_q == 5'h00) && !stall;
  // Busy drops idle in the cycle after a load
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      n_q    <= 6'h00;
      busy_q <= 5'h00;
    end
    else if (tx_load)
    begin
      got[n_q[4:0]] <= tx_byte;
      n_q           <= n_q + 6'h01;
      busy_q        <= 5'h14;
    end
    else if (busy_q != 5'h00)
      busy_q <= busy_q - 5'h01;
  end
endmodule
